/* design/clock_power_manager.sv */
/*
 Clock and power unit: register block, clock dividers and power-mode sequencer.
 Assumes clock_i is the undivided external clock and every input is synchronous to it.
*/
// What this block does
// - registers sit at base 0xFFFFAC00 plus offsets
// - reset enters active mode, oscillator disable low
// - core divider zero halts core clock
// - halted core also halts all peripheral clocks
// - standby: refresh on, watchdog off, oscillator runs
// - interrupt restarts core at full speed
// - sleep/stop: refresh and watchdog off, disable high
// - wake drops disable at once, then waits 32 cycles
// - low power needs watchdog off, never runs
// - refresh and watchdog as programmed while active
// - dividers for core, uarts, timers; external sources
// - core and peripheral clocks can be stopped
// - one-hot divider code, zero halts clock
// - source bit one selects external clock pin
`timescale 1ns/10ps
`include "clock_power_defines.svh"
module clock_power_manager #(
    parameter int NUM_PERIPH = 6,
    parameter int PERIPH_DIV_WIDTH = 9,
    parameter int CORE_DIV_WIDTH = 8
) (
    input  wire logic                        clock_i,
    input  wire logic                        arst_n_i,
    input  wire clock_power_pkg::bus_req_s   bus_req_i,
    output logic [31:0]                      rdata_o,
    input  wire logic                        irq_i,
    input  wire logic                        fiq_i,
    input  wire logic                        uart_ext_clk_i,
    input  wire logic                        timer_ext_clk_i,
    output logic                             core_clk_en_o,
    output logic [NUM_PERIPH-1:0]            periph_clk_en_o,
    output logic [2:0]                       aux_clk_en_o,
    output logic                             refresh_run_o,
    output logic                             watchdog_run_o,
    output logic                             osc_disable_out_o,
    output logic [3:0]                       power_mode_o
);
    if (NUM_PERIPH != 6 || PERIPH_DIV_WIDTH != 9 || CORE_DIV_WIDTH != 8)
    begin : g_bad_params
        $error("clock_power_manager: register map fixes 6 peripherals, 9-bit and 8-bit dividers");
    end

    localparam int HALF = NUM_PERIPH / 2;

    // registers
    logic [PERIPH_DIV_WIDTH-1:0] src_sel_reg;
    logic [PERIPH_DIV_WIDTH-1:0] periph_div_reg [NUM_PERIPH];
    logic [CORE_DIV_WIDTH-1:0] core_div_reg;
    logic [CORE_DIV_WIDTH-1:0] core_div_next;
    logic [1:0] power_ctrl_reg;
    logic [31:0] rdata_reg;
    clock_power_pkg::power_mode_e mode_reg;
    clock_power_pkg::power_mode_e mode_next;
    logic [5:0] stab_count_reg;
    logic [5:0] stab_count_next;
    logic [2:0] aux_en_reg;
    logic refresh_run_reg;
    logic watchdog_run_reg;
    logic osc_disable_reg;

    // address decode
    wire logic [7:0] offset = bus_req_i.addr[7:0];
    wire logic [31:0] base_addr = `CPU_BASE_ADDR;
    wire logic base_hit = (bus_req_i.addr[31:`CPU_BASE_HI_LSB] == base_addr[31:`CPU_BASE_HI_LSB]);
    wire logic wr_hit = bus_req_i.wr && base_hit;
    wire logic sel_src = (offset == `CPU_OFS_SRC_SEL);
    wire logic sel_core = (offset == `CPU_OFS_CORE_DIV);
    wire logic sel_ctrl = (offset == `CPU_OFS_POWER_CTRL);
    wire logic sel_stat = (offset == `CPU_OFS_POWER_STAT);

    function automatic logic [7:0] periph_offset(input int idx);
        case (idx)
            0: periph_offset = `CPU_OFS_UART0_DIV;
            1: periph_offset = `CPU_OFS_UART1_DIV;
            2: periph_offset = `CPU_OFS_UART2_DIV;
            3: periph_offset = `CPU_OFS_TIMER0_DIV;
            4: periph_offset = `CPU_OFS_TIMER1_DIV;
            default: periph_offset = `CPU_OFS_TIMER2_DIV;
        endcase
    endfunction

    logic [NUM_PERIPH-1:0] sel_periph;
    for (genvar i = 0; i < NUM_PERIPH; i++)
    begin : g_decode
        assign sel_periph[i] = (offset == periph_offset(i));
    end

    // state derived from registers and the interrupt inputs
    wire logic core_halted = (core_div_reg == `CPU_CORE_HALT);
    wire logic refresh_en = power_ctrl_reg[`CPU_BIT_REFRESH_EN];
    wire logic watchdog_en = power_ctrl_reg[`CPU_BIT_WATCHDOG_EN];
    wire logic wake_req = irq_i || fiq_i;
    wire logic is_active = (mode_reg == clock_power_pkg::MODE_ACTIVE);
    wire logic is_standby = (mode_reg == clock_power_pkg::MODE_STANDBY);
    wire logic [PERIPH_DIV_WIDTH-1:0] aux_bits = src_sel_reg >> `CPU_SRC_AUX_LSB;

    // read mux
    logic [31:0] periph_rd;
    always_comb
    begin
        periph_rd = 32'h0000_0000;
        for (int i = 0; i < NUM_PERIPH; i++)
        begin
            if (sel_periph[i])
            begin
                periph_rd = {{(32-PERIPH_DIV_WIDTH){1'b0}}, periph_div_reg[i]};
            end
        end
    end

    wire logic [31:0] rd_mux =
        !base_hit ? 32'h0000_0000 :
        sel_src   ? {{(32-PERIPH_DIV_WIDTH){1'b0}}, src_sel_reg} :
        sel_core  ? {{(32-CORE_DIV_WIDTH){1'b0}}, core_div_reg} :
        sel_ctrl  ? {30'h0000_0000, power_ctrl_reg} :
        sel_stat  ? {27'h000_0000, core_halted, mode_reg} :
        periph_rd;

    // power-mode sequencer
    always_comb
    begin
        mode_next = mode_reg;
        stab_count_next = stab_count_reg;
        core_div_next = core_div_reg;
        if (wr_hit && sel_core)
        begin
            core_div_next = bus_req_i.wdata[CORE_DIV_WIDTH-1:0];
        end
        case (mode_reg)
            clock_power_pkg::MODE_ACTIVE:
            begin
                if (core_halted && wake_req)
                begin
                    // halted core with watchdog on stays active; an interrupt still restarts it
                    core_div_next = `CPU_CORE_FULL_SPEED;
                end
                else if (core_halted && !watchdog_en)
                begin
                    if (refresh_en)
                    begin
                        mode_next = clock_power_pkg::MODE_STANDBY;
                    end
                    else
                    begin
                        mode_next = clock_power_pkg::MODE_SLEEP;
                    end
                end
            end
            clock_power_pkg::MODE_STANDBY:
            begin
                if (wake_req)
                begin
                    // no stabilisation: the oscillator never stopped
                    core_div_next = `CPU_CORE_FULL_SPEED;
                    mode_next = clock_power_pkg::MODE_ACTIVE;
                end
            end
            clock_power_pkg::MODE_SLEEP:
            begin
                if (wake_req)
                begin
                    stab_count_next = 6'h00;
                    mode_next = clock_power_pkg::MODE_WAKE;
                end
            end
            clock_power_pkg::MODE_WAKE:
            begin
                if (stab_count_reg == `CPU_STAB_CYCLES - 6'h01)
                begin
                    core_div_next = `CPU_CORE_FULL_SPEED;
                    mode_next = clock_power_pkg::MODE_ACTIVE;
                end
                else
                begin
                    stab_count_next = stab_count_reg + 6'h01;
                end
            end
            default:
            begin
                mode_next = clock_power_pkg::MODE_ACTIVE;
            end
        endcase
    end

    // outputs of the next mode, registered so each output is a flip-flop
    wire logic next_active = (mode_next == clock_power_pkg::MODE_ACTIVE);
    wire logic next_standby = (mode_next == clock_power_pkg::MODE_STANDBY);
    wire logic next_low_osc = (mode_next == clock_power_pkg::MODE_SLEEP);
    wire logic refresh_run_next = refresh_en && (next_active || next_standby);
    wire logic watchdog_run_next = watchdog_en && next_active;
    wire logic core_halt_next = (core_div_next == `CPU_CORE_HALT);
    wire logic [2:0] aux_en_next = core_halt_next ? 3'h0 : aux_bits[2:0];

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            mode_reg <= clock_power_pkg::MODE_ACTIVE;
            stab_count_reg <= 6'h00;
            core_div_reg <= `CPU_RST_CORE_DIV;
            refresh_run_reg <= 1'b0;
            watchdog_run_reg <= 1'b0;
            osc_disable_reg <= 1'b0;
            aux_en_reg <= 3'h0;
        end
        else
        begin
            mode_reg <= mode_next;
            stab_count_reg <= stab_count_next;
            core_div_reg <= core_div_next;
            refresh_run_reg <= refresh_run_next;
            watchdog_run_reg <= watchdog_run_next;
            osc_disable_reg <= next_low_osc;
            aux_en_reg <= aux_en_next;
        end
    end

    // software registers
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            src_sel_reg <= `CPU_RST_SRC_SEL;
            power_ctrl_reg <= `CPU_RST_POWER_CTRL;
        end
        else if (wr_hit)
        begin
            if (sel_src)
            begin
                src_sel_reg <= bus_req_i.wdata[PERIPH_DIV_WIDTH-1:0];
            end
            if (sel_ctrl)
            begin
                power_ctrl_reg <= bus_req_i.wdata[1:0];
            end
        end
    end

    for (genvar i = 0; i < NUM_PERIPH; i++)
    begin : g_periph_reg
        always_ff @(posedge clock_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                periph_div_reg[i] <= `CPU_RST_PERIPH_DIV;
            end
            else if (wr_hit && sel_periph[i])
            begin
                periph_div_reg[i] <= bus_req_i.wdata[PERIPH_DIV_WIDTH-1:0];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            rdata_reg <= bus_req_i.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // dividers
    clock_divider #(
        .WIDTH(CORE_DIV_WIDTH)
    ) u_core_div (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .divisor_i(core_div_reg),
        .run_i(1'b1),
        .ext_sel_i(1'b0),
        .ext_clk_i(1'b0),
        .tick_o(core_clk_en_o)
    );

    for (genvar i = 0; i < NUM_PERIPH; i++)
    begin : g_periph_div
        clock_divider #(
            .WIDTH(PERIPH_DIV_WIDTH)
        ) u_div (
            .clock_i(clock_i),
            .arst_n_i(arst_n_i),
            .divisor_i(periph_div_reg[i]),
            .run_i(!core_halted),
            .ext_sel_i(src_sel_reg[`CPU_SRC_EXT_LSB + i]),
            .ext_clk_i(i < HALF ? uart_ext_clk_i : timer_ext_clk_i),
            .tick_o(periph_clk_en_o[i])
        );
    end

    assign rdata_o = rdata_reg;
    assign aux_clk_en_o = aux_en_reg;
    assign refresh_run_o = refresh_run_reg;
    assign watchdog_run_o = watchdog_run_reg;
    assign osc_disable_out_o = osc_disable_reg;
    assign power_mode_o = mode_reg;
endmodule

/* design/clock_power_defines.svh */
/*
 Address map, reset values and timing counts of the clock and power unit.
 Assumes inclusion by bare name from the clock_power_manager module; the package does not include it.
*/
`ifndef CLOCK_POWER_DEFINES_SVH
`define CLOCK_POWER_DEFINES_SVH

`define CPU_BASE_ADDR       32'hFFFFAC00
`define CPU_BASE_HI_LSB     8
`define CPU_OFS_SRC_SEL     8'h04
`define CPU_OFS_UART0_DIV   8'h08
`define CPU_OFS_UART1_DIV   8'h0C
`define CPU_OFS_UART2_DIV   8'h10
`define CPU_OFS_TIMER0_DIV  8'h18
`define CPU_OFS_TIMER1_DIV  8'h1C
`define CPU_OFS_TIMER2_DIV  8'h20
`define CPU_OFS_CORE_DIV    8'h28
`define CPU_OFS_POWER_CTRL  8'h2C
`define CPU_OFS_POWER_STAT  8'h30

`define CPU_RST_SRC_SEL     9'h000
`define CPU_RST_PERIPH_DIV  9'h001
`define CPU_RST_CORE_DIV    8'h01
`define CPU_CORE_FULL_SPEED 8'h01
`define CPU_CORE_HALT       8'h00
`define CPU_RST_POWER_CTRL  2'h0

`define CPU_BIT_REFRESH_EN  0
`define CPU_BIT_WATCHDOG_EN 1
`define CPU_SRC_EXT_LSB     0
`define CPU_SRC_AUX_LSB     6

`define CPU_STAB_CYCLES     6'h20

`endif

/* design/clock_power_pkg.sv */
/*
 Types shared by the clock and power unit files.
 Assumes the defines header sits beside it.
*/
package clock_power_pkg;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;

    typedef enum logic [3:0] {
        MODE_ACTIVE  = 4'h1,
        MODE_STANDBY = 4'h2,
        MODE_SLEEP   = 4'h4,
        MODE_WAKE    = 4'h8
    } power_mode_e;

endpackage

/* design/clock_divider.sv */
/*
 One-hot clock divider producing a one-cycle enable pulse.
 Assumes divisor is zero or one-hot and ext_clk_i is synchronous to clock_i.
*/
`timescale 1ns/10ps
module clock_divider #(
    parameter int WIDTH = 9
) (
    input  wire logic             clock_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] divisor_i,
    input  wire logic             run_i,
    input  wire logic             ext_sel_i,
    input  wire logic             ext_clk_i,
    output logic                  tick_o
);
    if (WIDTH < 1 || WIDTH > 16)
    begin : g_bad_width
        $error("clock_divider: WIDTH must be 1 to 16");
    end

    // low bits that must all be set for a divide-by-divisor pulse
    function automatic logic [WIDTH-1:0] period_mask(input logic [WIDTH-1:0] d);
        period_mask = d - {{(WIDTH-1){1'b0}}, 1'b1};
    endfunction

    logic [WIDTH-1:0] count_reg;
    logic ext_prev_reg;
    logic tick_reg;

    wire logic [WIDTH-1:0] mask = period_mask(divisor_i);
    wire logic halted = (divisor_i == '0);
    // free-running count: a new divisor takes effect on a pulse boundary of the shorter period
    wire logic int_tick = !halted && ((count_reg & mask) == mask);
    wire logic ext_tick = ext_clk_i && !ext_prev_reg;
    wire logic tick_next = run_i && (ext_sel_i ? ext_tick : int_tick);

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            count_reg <= '0;
            ext_prev_reg <= 1'b0;
            tick_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            ext_prev_reg <= ext_clk_i;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;
endmodule

/* dv/clock_power_manager_assertions.sv */
/*
 Checker for the clock and power unit's mode, wake and clock-stop behaviour.
 Assumes binding to clock_power_manager with one clock and async active-low reset.
*/
`timescale 1ns/10ps
module clock_power_manager_assertions #(
    parameter int NUM_PERIPH = 6
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic irq_i,
    input wire logic fiq_i,
    input wire logic core_clk_en_o,
    input wire logic [NUM_PERIPH-1:0] periph_clk_en_o,
    input wire logic [2:0] aux_clk_en_o,
    input wire logic refresh_run_o,
    input wire logic watchdog_run_o,
    input wire logic osc_disable_out_o,
    input wire logic [3:0] power_mode_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    logic [6:0] wake_cnt;
    wire in_wake = power_mode_o == 4'h8;
    wire irq_any = irq_i | fiq_i;
    // counts stabilisation cycles so the length is checked exactly
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            wake_cnt <= 7'h00;
        else
            wake_cnt <= in_wake ? wake_cnt + 7'h01 : 7'h00;
    end
    property p_osc_level;
        osc_disable_out_o == (power_mode_o == 4'h4);
    endproperty
    a_osc_level: assert property (p_osc_level) else $error("oscillator disable wrong for mode");
    property p_halt_clocks;
        power_mode_o != 4'h1 |-> !core_clk_en_o && periph_clk_en_o == '0 && aux_clk_en_o == 3'h0;
    endproperty
    a_halt_clocks: assert property (p_halt_clocks) else $error("clock pulse in low power");
    property p_wdog_off;
        power_mode_o != 4'h1 && $past(power_mode_o) != 4'h1 |-> !watchdog_run_o;
    endproperty
    a_wdog_off: assert property (p_wdog_off) else $error("watchdog runs in low power");
    property p_refresh_off;
        (power_mode_o & 4'hC) != 4'h0 && ($past(power_mode_o) & 4'hC) != 4'h0 |-> !refresh_run_o;
    endproperty
    a_refresh_off: assert property (p_refresh_off) else $error("refresh runs in sleep");
    property p_standby_exit;
        power_mode_o == 4'h2 && irq_any |=> power_mode_o == 4'h1;
    endproperty
    a_standby_exit: assert property (p_standby_exit) else $error("standby did not exit");
    property p_sleep_exit;
        power_mode_o == 4'h4 && irq_any |=> in_wake && !osc_disable_out_o;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep did not start wake");
    property p_wake_len;
        !in_wake && $past(in_wake) |-> wake_cnt == 7'h20;
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("stabilisation length wrong");
    property p_wake_restart;
        $fell(in_wake) |-> ##1 core_clk_en_o [*3];
    endproperty
    a_wake_restart: assert property (p_wake_restart) else $error("core not at full speed");
    c_standby: cover property (power_mode_o == 4'h2);
    c_sleep: cover property (power_mode_o == 4'h4);
    c_wake_done: cover property ($fell(in_wake));
endmodule

bind clock_power_manager clock_power_manager_assertions #(.NUM_PERIPH(NUM_PERIPH)) i_checker (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .irq_i(irq_i), .fiq_i(fiq_i),
    .core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o), .aux_clk_en_o(aux_clk_en_o),
    .refresh_run_o(refresh_run_o), .watchdog_run_o(watchdog_run_o),
    .osc_disable_out_o(osc_disable_out_o), .power_mode_o(power_mode_o)
);

/* dv/osc_model.sv */
/*
 External oscillator model gated by the unit's disable output.
 Assumes clock_i is the free bench clock; ext_clk_o feeds the uart and timer pins.
*/
`timescale 1ns/10ps
module osc_model (
    input wire logic clock_i,
    input wire logic osc_disable_i,
    output logic ext_clk_o,
    output logic running_o
);
    logic [2:0] phase = 3'h0;
    logic ext_q = 1'b0;
    logic run_q = 1'b1;
    assign ext_clk_o = ext_q;
    assign running_o = run_q;
    // a halted oscillator stands low, it does not freeze mid-cycle
    always @(posedge clock_i)
    begin
        if (osc_disable_i)
        begin
            run_q <= 1'b0;
            ext_q <= 1'b0;
            phase <= 3'h0;
        end
        else
        begin
            run_q <= 1'b1;
            phase <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
            if (phase == 3'h4)
                ext_q <= ~ext_q;
        end
    end
endmodule

/* dv/clock_power_manager_test.sv */
/*
 Self-checking bench for the clock and power unit.
 Assumes the package, the design, the oscillator model and the checker are compiled first.
*/
`timescale 1ns/10ps
module clock_power_manager_test;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    clock_power_pkg::bus_req_s req = '0;
    logic irq = 1'b0;
    logic fast_interrupt_request = 1'b0;
    logic ext_clk, osc_running, core_en, refresh_run, wdog_run, osc_dis;
    logic [31:0] rdata;
    logic [5:0] periph_en;
    logic [2:0] aux_en;
    logic [3:0] mode;
    logic [7:0] ofs_tab [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h28};
    int miscompares = 0;
    int comparisons = 0;
    int n;

    initial forever #20 clock_i = ~clock_i;

    clock_power_manager i_dut (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .bus_req_i(req), .rdata_o(rdata), .irq_i(irq), .fiq_i(fast_interrupt_request),
        .uart_ext_clk_i(ext_clk), .timer_ext_clk_i(ext_clk), .core_clk_en_o(core_en),
        .periph_clk_en_o(periph_en), .aux_clk_en_o(aux_en), .refresh_run_o(refresh_run),
        .watchdog_run_o(wdog_run), .osc_disable_out_o(osc_dis), .power_mode_o(mode)
    );
    osc_model i_osc (.clock_i(clock_i), .osc_disable_i(osc_dis), .ext_clk_o(ext_clk), .running_o(osc_running));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        @(posedge clock_i);
        req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        req <= '0;
    endtask
    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        @(posedge clock_i);
        req <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        req <= '0;
        #1 chk(rdata, exp, "read data");
    endtask
    // idx below zero counts core pulses
    task automatic pulses(input int idx, input int cycles);
        n = 0;
        repeat (cycles)
        begin
            @(posedge clock_i);
            #1 n += (idx < 0) ? int'(core_en) : int'(periph_en[idx]);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge clock_i);
        arst_n_i <= 1'b1;
        #1 chk({mode, osc_dis}, {4'h1, 1'b0}, "reset mode");
        foreach (ofs_tab[i])
            rd(32'hFFFFAC00 | 32'(ofs_tab[i]), (i == 0) ? 32'h0 : 32'h1);
        // upper data bits must be dropped; core divider is one bit narrower
        foreach (ofs_tab[i])
        begin
            wr(32'hFFFFAC00 | 32'(ofs_tab[i]), (i == 7) ? 32'hFFFFFF80 : 32'hFFFFFF00);
            rd(32'hFFFFAC00 | 32'(ofs_tab[i]), (i == 7) ? 32'h80 : 32'h100);
            wr(32'hFFFFAC00 | 32'(ofs_tab[i]), (i == 0) ? 32'h0 : 32'h1);
        end
        wr(32'hFFFFAC14, 32'h1);
        rd(32'hFFFFAC14, 32'h0);
        rd(32'hFFFFAB04, 32'h0);
        wr(32'hFFFFAC08, 32'h4);
        pulses(0, 16);
        chk(32'(n), 32'h4, "uart0 divide by 4");
        wr(32'hFFFFAC20, 32'h100);
        pulses(5, 512);
        chk(32'(n), 32'h2, "timer2 divide by 256");
        wr(32'hFFFFAC28, 32'h2);
        pulses(-1, 16);
        chk(32'(n), 32'h8, "core divide by 2");
        wr(32'hFFFFAC28, 32'h1);
        wr(32'hFFFFAC04, 32'h1);
        @(posedge ext_clk);
        repeat (5) @(posedge clock_i);
        pulses(0, 40);
        chk(32'(n), 32'h4, "uart0 on external clock");
        wr(32'hFFFFAC04, 32'h140);
        // enables are registered from the source register, one edge after the write lands
        @(posedge clock_i);
        #1 chk(32'(aux_en), 32'h5, "aux enables");
        wr(32'hFFFFAC2C, 32'h1);
        wr(32'hFFFFAC28, 32'h0);
        repeat (2) @(posedge clock_i);
        #1 chk({mode, osc_dis, refresh_run, wdog_run}, {4'h2, 3'b010}, "standby");
        chk({core_en, periph_en, aux_en}, 32'h0, "clocks stopped");
        @(posedge clock_i);
        irq <= 1'b1;
        @(posedge clock_i);
        irq <= 1'b0;
        #1 chk(32'(mode), 32'h1, "standby exit");
        rd(32'hFFFFAC28, 32'h1);
        pulses(-1, 8);
        chk(32'(n), 32'h8, "core full speed");
        wr(32'hFFFFAC2C, 32'h3);
        wr(32'hFFFFAC28, 32'h0);
        repeat (3) @(posedge clock_i);
        #1 chk({mode, wdog_run, periph_en}, {4'h1, 1'b1, 6'h0}, "watchdog blocks low power");
        rd(32'hFFFFAC30, 32'h11);
        rd(32'hFFFFAC2C, 32'h3);
        @(posedge clock_i);
        fast_interrupt_request <= 1'b1;
        @(posedge clock_i);
        fast_interrupt_request <= 1'b0;
        rd(32'hFFFFAC28, 32'h1);
        wr(32'hFFFFAC2C, 32'h0);
        wr(32'hFFFFAC28, 32'h0);
        repeat (2) @(posedge clock_i);
        #1 chk({mode, osc_dis, refresh_run, osc_running}, {4'h4, 3'b100}, "sleep");
        @(posedge clock_i);
        irq <= 1'b1;
        @(posedge clock_i);
        irq <= 1'b0;
        #1 chk({mode, osc_dis}, {4'h8, 1'b0}, "wake start");
        n = 0;
        while (mode === 4'h8 && n < 100)
        begin
            @(posedge clock_i);
            #1 n++;
        end
        chk(32'(n), 32'h20, "stabilisation cycles");
        pulses(-1, 4);
        chk(32'(n), 32'h4, "core restart");
        stop_test();
    end

    initial
    begin
        repeat (5000) @(posedge clock_i);
        miscompares++;
        stop_test();
    end
endmodule
